// >>> pkg/ldd_regs.svh
`ifndef LDD_REGS_SVH
`define LDD_REGS_SVH
// --------------------------------
// register indices, byte addr = 4*idx
// --------------------------------
`define LDD_IDX_AUTO 8'h43
`define LDD_IDX_DET 8'h44
`define LDD_IDX_LCT 8'h45
`define LDD_IDX_RTT 8'h46
`define LDD_IDX_FEED 8'h47
`define LDD_IDX_OHV 8'h48
`define LDD_IDX_CMV 8'h49
`define LDD_IDX_IST 8'h50
`define LDD_IDX_IMSK 8'h51
// --------------------------------
// reset values
// --------------------------------
`define LDD_RST_AUTO 3'h3
`define LDD_RST_TIME 7'h0a
`define LDD_RST_FEED 3'h0
`define LDD_RST_OHV 7'h20
`define LDD_RST_CMV 6'h02
// --------------------------------
// field positions
// --------------------------------
`define LDD_B_UNF 2
`define LDD_B_RT 1
`define LDD_B_LC 0
`define LDD_B_POL 6
`define LDD_B_MAN 5
`define LDD_B_ART 2
`define LDD_B_ALC 1
// --------------------------------
// timing
// --------------------------------
`define LDD_TICK_NS 1250000
`define LDD_CLK_NS 25
`endif

// >>> pkg/ldd_pkg.sv
package ldd_pkg;
    typedef struct packed {
        logic [2:0] feed_current_code;
        logic on_hook_polarity;
        logic [5:0] on_hook_level;
        logic [5:0] common_mode_level;
        logic manual_differential_select;
    } ldd_feed_t;

    typedef struct packed {
        logic flag;
        logic last;
        logic [6:0] cnt;
    } ldd_deb_t;

    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } ldd_bus_t;
endpackage

// >>> core/ldd_core.sv
// What this block does
// - status bit 2 shows combined detector output live, before debounce
// - that unfiltered bit is 0 while a threshold is exceeded, else 1
// - status bit 1 is the debounced ring-trip flag, 1 once detected
// - status bit 0 is the debounced loop-closure flag, 1 once detected
// - loop-closure filter needs steady input for its 7-bit interval of 1.25 ms ticks
// - ring-trip filter needs steady input for its own 7-bit interval of 1.25 ms ticks
// - 3-bit feed current code drives the constant loop current setting
// - on-hook register bit 6 selects tip-minus-ring polarity
// - 6-bit on-hook level sets magnitude, 1.5 V per code, reset 48 V
// - 6-bit common-mode level, negative 1.5 V steps, reset -3 V
// - with auto ring-trip answer, filtered ring trip requests active state
// - with auto loop-closure answer, filtered closure requests active state
// - manual differential select makes line follow on-hook level
`include "ldd_regs.svh"

module ldd_core
    import ldd_pkg::*;
#(
    parameter int TICK_CYCLES = `LDD_TICK_NS / `LDD_CLK_NS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // detector pins, active low
    input wire logic ring_trip_det_n,
    input wire logic loop_closure_det_n,
    // linefeed controls
    output ldd_feed_t feed,
    output logic enter_active,
    // interrupt
    output logic irq
);

    localparam int TW = $clog2(TICK_CYCLES + 1);

    // --------------------------------
    // debounce step
    // --------------------------------
    function automatic ldd_deb_t deb_step(
        input ldd_deb_t s,
        input logic hit,
        input logic tick,
        input logic [6:0] lim
    );
        ldd_deb_t n;
        n = s;
        if (hit != s.last) begin
            n.last = hit;
            n.cnt = 7'h00;
        end else if (tick && s.cnt >= lim) begin
            // the first tick after a change is partial, so one more tick
            // keeps the steady time from falling short of the interval
            n.flag = hit;
        end else if (tick) begin
            n.cnt = s.cnt + 7'h01;
        end
        return n;
    endfunction

    // --------------------------------
    // pin synchronisers
    // --------------------------------
    logic [1:0] rt_sy_ff;
    logic [1:0] lc_sy_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rt_sy_ff <= 2'h3;
            lc_sy_ff <= 2'h3;
        end else begin
            rt_sy_ff <= {rt_sy_ff[0], ring_trip_det_n};
            lc_sy_ff <= {lc_sy_ff[0], loop_closure_det_n};
        end
    end

    wire rt_s = rt_sy_ff[1];
    wire lc_s = lc_sy_ff[1];
    wire unf_s = rt_s & lc_s;

    // --------------------------------
    // 1.25 ms tick
    // --------------------------------
    logic [TW-1:0] tick_cnt_ff;
    wire tick_end = (tick_cnt_ff == TW'(TICK_CYCLES - 1));
    wire [TW-1:0] nxt_tick_cnt =
        tick_end ? '0 : tick_cnt_ff + TW'(1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_ff <= '0;
        end else begin
            tick_cnt_ff <= nxt_tick_cnt;
        end
    end

    // --------------------------------
    // registers
    // --------------------------------
    ldd_bus_t bus_ff;
    logic [2:0] auto_ff;
    logic [6:0] lct_ff;
    logic [6:0] rtt_ff;
    logic [2:0] feed_ff;
    logic [6:0] ohv_ff;
    logic [5:0] cmv_ff;
    logic [1:0] ist_ff;
    logic [1:0] imsk_ff;
    logic [7:0] rdat_ff;
    logic act_ff;
    ldd_deb_t rt_ff;
    ldd_deb_t lc_ff;

    // --------------------------------
    // bus decode
    // --------------------------------
    wire req = read | write;
    wire [7:0] idx = address[9:2];
    wire wr_go = write & (bus_ff == BUS_ACK)
        & byteenable[0];
    wire rd_go = read & (bus_ff == BUS_IDLE);
    wire [7:0] wd = writedata[7:0];
    wire sel_auto = (idx == `LDD_IDX_AUTO);
    wire sel_det = (idx == `LDD_IDX_DET);
    wire sel_lct = (idx == `LDD_IDX_LCT);
    wire sel_rtt = (idx == `LDD_IDX_RTT);
    wire sel_feed = (idx == `LDD_IDX_FEED);
    wire sel_ohv = (idx == `LDD_IDX_OHV);
    wire sel_cmv = (idx == `LDD_IDX_CMV);
    wire sel_ist = (idx == `LDD_IDX_IST);
    wire sel_imsk = (idx == `LDD_IDX_IMSK);
    wire sel_any = sel_auto | sel_det | sel_lct | sel_rtt | sel_feed
        | sel_ohv | sel_cmv | sel_ist | sel_imsk;
    wire ldd_bus_t nxt_bus =
        (bus_ff == BUS_IDLE && req) ? BUS_ACK : BUS_IDLE;

    assign waitrequest = req & (bus_ff == BUS_IDLE);

    // --------------------------------
    // read mux, unused bits zero
    // --------------------------------
    wire [7:0] auto_rd = {2'h0,
        auto_ff[2], 2'h0, auto_ff[1:0], 1'b0};
    wire [7:0] det_rd = {5'h00, unf_s,
        rt_ff.flag, lc_ff.flag};
    wire [7:0] nxt_rdat =
        sel_auto ? auto_rd :
        sel_det ? det_rd :
        sel_lct ? {1'b0, lct_ff} :
        sel_rtt ? {1'b0, rtt_ff} :
        sel_feed ? {5'h00, feed_ff} :
        sel_ohv ? {1'b0, ohv_ff} :
        sel_cmv ? {2'h0, cmv_ff} :
        sel_ist ? {6'h00, ist_ff} :
        sel_imsk ? {6'h00, imsk_ff} :
        8'h00;

    assign readdata = {24'h000000, rdat_ff};

    // --------------------------------
    // debounce filters
    // --------------------------------
    wire ldd_deb_t nxt_rt =
        deb_step(rt_ff, ~rt_s, tick_end, rtt_ff);
    wire ldd_deb_t nxt_lc =
        deb_step(lc_ff, ~lc_s, tick_end, lct_ff);
    wire rt_rise = nxt_rt.flag & ~rt_ff.flag;
    wire lc_rise = nxt_lc.flag & ~lc_ff.flag;
    wire [1:0] ev = {nxt_rt.flag ^ rt_ff.flag,
        nxt_lc.flag ^ lc_ff.flag};
    wire nxt_act = (auto_ff[`LDD_B_ART - 1] & rt_rise)
        | (auto_ff[`LDD_B_ALC - 1] & lc_rise);

    // --------------------------------
    // interrupt status, set beats clear
    // --------------------------------
    wire [1:0] ist_clr = (wr_go & sel_ist) ? wd[1:0] : 2'h0;
    wire [1:0] nxt_ist = (ist_ff & ~ist_clr) | ev;

    assign irq = |(ist_ff & imsk_ff);

    // --------------------------------
    // state
    // --------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_ff <= BUS_IDLE;
            rdat_ff <= 8'h00;
            rt_ff <= '0;
            lc_ff <= '0;
            ist_ff <= 2'h0;
            act_ff <= 1'b0;
        end else begin
            bus_ff <= nxt_bus;
            if (rd_go) begin
                rdat_ff <= nxt_rdat;
            end
            rt_ff <= nxt_rt;
            lc_ff <= nxt_lc;
            ist_ff <= nxt_ist;
            act_ff <= nxt_act;
        end
    end

    // status register has no write path
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            auto_ff <= `LDD_RST_AUTO;
            lct_ff <= `LDD_RST_TIME;
            rtt_ff <= `LDD_RST_TIME;
            feed_ff <= `LDD_RST_FEED;
            ohv_ff <= `LDD_RST_OHV;
            cmv_ff <= `LDD_RST_CMV;
            imsk_ff <= 2'h0;
        end else if (wr_go) begin
            if (sel_auto) begin
                auto_ff <= {wd[`LDD_B_MAN],
                    wd[`LDD_B_ART], wd[`LDD_B_ALC]};
            end
            if (sel_lct) begin
                lct_ff <= wd[6:0];
            end
            if (sel_rtt) begin
                rtt_ff <= wd[6:0];
            end
            if (sel_feed) begin
                feed_ff <= wd[2:0];
            end
            if (sel_ohv) begin
                ohv_ff <= wd[6:0];
            end
            if (sel_cmv) begin
                cmv_ff <= wd[5:0];
            end
            if (sel_imsk) begin
                imsk_ff <= wd[1:0];
            end
        end
    end

    // --------------------------------
    // linefeed outputs
    // --------------------------------
    assign feed.feed_current_code = feed_ff;
    assign feed.on_hook_polarity = ohv_ff[`LDD_B_POL];
    assign feed.on_hook_level = ohv_ff[5:0];
    assign feed.common_mode_level = cmv_ff;
    assign feed.manual_differential_select = auto_ff[2];
    assign enter_active = act_ff;

    // --------------------------------
    // assertions
    // --------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_unf_bit_read: assert property (
        (rd_go && sel_det) |=> readdata[`LDD_B_UNF] == $past(unf_s))
        else $error("unfiltered bit not live");
    a_unf_active_low: assert property (
        (rd_go && sel_det && !rt_s) |=> !readdata[`LDD_B_UNF])
        else $error("unfiltered bit not active low");
    a_rt_flag_read: assert property (
        (rd_go && sel_det) |=> readdata[`LDD_B_RT] == $past(rt_ff.flag))
        else $error("ring trip flag misread");
    a_lc_flag_read: assert property (
        (rd_go && sel_det) |=> readdata[`LDD_B_LC] == $past(lc_ff.flag))
        else $error("loop closure flag misread");
    a_lc_steady_time: assert property (
        $changed(lc_ff.flag) |-> $past(lc_ff.cnt) >= $past(lct_ff)
            && $past(tick_end) && lc_ff.flag == $past(lc_ff.last))
        else $error("loop closure flag changed early");
    a_rt_steady_time: assert property (
        $changed(rt_ff.flag) |-> $past(rt_ff.cnt) >= $past(rtt_ff)
            && $past(tick_end) && rt_ff.flag == $past(rt_ff.last))
        else $error("ring trip flag changed early");
    a_feed_write: assert property (
        (wr_go && sel_feed) |=> feed.feed_current_code == $past(wd[2:0]))
        else $error("feed code not applied");
    a_ohv_write: assert property (
        (wr_go && sel_ohv) |=> feed.on_hook_polarity == $past(wd[6])
            && feed.on_hook_level == $past(wd[5:0]))
        else $error("on-hook setting not applied");
    a_cmv_write: assert property (
        (wr_go && sel_cmv) |=> feed.common_mode_level == $past(wd[5:0]))
        else $error("common mode not applied");
    a_auto_ring: assert property (
        ($rose(rt_ff.flag) && $past(auto_ff[1])) |-> enter_active)
        else $error("no active request on ring trip");
    a_auto_loop: assert property (
        ($rose(lc_ff.flag) && $past(auto_ff[0])) |-> enter_active)
        else $error("no active request on loop closure");
    a_man_diff: assert property (
        (wr_go && sel_auto) |=>
            feed.manual_differential_select == $past(wd[`LDD_B_MAN]))
        else $error("manual select not applied");
    a_det_upper_zero: assert property (
        (rd_go && sel_det) |=> readdata[7:3] == 5'h00)
        else $error("status upper bits not zero");
    a_deb_restart: assert property (
        $changed(lc_ff.last) |-> lc_ff.cnt == 7'h00)
        else $error("debounce count not restarted");
    a_rt_restart: assert property (
        $changed(rt_ff.last) |-> rt_ff.cnt == 7'h00)
        else $error("ring trip count not restarted");
    a_lct_write: assert property (
        (wr_go && sel_lct) |=> lct_ff == $past(wd[6:0]))
        else $error("loop closure interval not applied");
    a_rtt_write: assert property (
        (wr_go && sel_rtt) |=> rtt_ff == $past(wd[6:0]))
        else $error("ring trip interval not applied");
    a_feed_hold: assert property (
        !(wr_go && sel_feed) |=> $stable(feed.feed_current_code))
        else $error("feed code changed without write");
    a_act_on_rise: assert property (
        enter_active |-> $rose(rt_ff.flag) || $rose(lc_ff.flag))
        else $error("active request without a new detection");
    a_auto_read: assert property (
        (rd_go && sel_auto) |=> readdata[`LDD_B_MAN] == $past(feed.manual_differential_select))
        else $error("manual select misread");
    a_unmapped_zero: assert property (
        (rd_go && !sel_any) |=> readdata == 32'h00000000)
        else $error("unmapped register not zero");
    a_ist_set_wins: assert property (
        (ev != 2'h0) |=> (ist_ff & $past(ev)) == $past(ev))
        else $error("status event lost");
    a_ist_w1c: assert property (
        (wr_go && sel_ist && ev == 2'h0) |=> (ist_ff & $past(wd[1:0])) == 2'h0)
        else $error("status bit not cleared");

    c_ring_trip: cover property ($rose(rt_ff.flag));
    c_loop_close: cover property ($rose(lc_ff.flag));
    c_irq: cover property ($rose(irq));
    c_write_ack: cover property (wr_go && sel_ohv);
    c_ring_answer: cover property (enter_active && rt_ff.flag);

endmodule // ldd_core

// >>> tb/ldd_line_model.sv
// --------------------------------
// subscriber line seen by the detectors
// --------------------------------
module ldd_line_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // line state set by the bench
    input wire logic hook_off,
    input wire logic ringing,
    // detector pins, active low
    output logic ring_trip_det_n,
    output logic loop_closure_det_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // off-hook while ringing trips the ring, otherwise it closes the loop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ring_trip_det_n <= 1'h1;
            loop_closure_det_n <= 1'h1;
        end else begin
            ring_trip_det_n <= ~(hook_off & ringing);
            loop_closure_det_n <= ~(hook_off & ~ringing);
        end
    end
endmodule // ldd_line_model

// >>> tb/ldd_core_tb_top.sv
module ldd_core_tb_top;
    import ldd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 4;
    logic clk, rst, read, write, hook_off, ringing, irq, enter_active, waitrequest;
    logic rt_n, lc_n;
    logic [9:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable;
    ldd_feed_t feed;
    logic [7:0] q, c0;
    logic [7:0] n_act = 8'h00;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [7:0] idx_tab [9] = '{8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h50, 8'h51};
    logic [7:0] rst_tab [9] = '{8'h06, 8'h04, 8'h0a, 8'h0a, 8'h00, 8'h20, 8'h02, 8'h00, 8'h00};
    logic [7:0] msk_tab [9] = '{8'h26, 8'h04, 8'h7f, 8'h7f, 8'h07, 8'h7f, 8'h3f, 8'h00, 8'h03};

    ldd_core #(.TICK_CYCLES(TICK)) u_ldd_core (.clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .ring_trip_det_n(rt_n), .loop_closure_det_n(lc_n), .feed(feed),
        .enter_active(enter_active), .irq(irq));
    ldd_line_model u_ldd_line_model (.clk(clk), .rst(rst), .hook_off(hook_off), .ringing(ringing),
        .ring_trip_det_n(rt_n), .loop_closure_det_n(lc_n));

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (enter_active === 1'h1) n_act <= n_act + 8'h01;
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    // --------------------------------
    // report and compare
    // --------------------------------
    task automatic wrap_up();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic chk_feed(input ldd_feed_t got, input ldd_feed_t exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t feed got %h exp %h", $time, got, exp);
        end
    endtask

    // --------------------------------
    // avalon-mm master
    // --------------------------------
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] r);
        @(posedge clk);
        address <= {idx, 2'h0};
        writedata <= {24'h0, d};
        write <= wr;
        read <= ~wr;
        do @(posedge clk); while (waitrequest !== 1'h0);
        r = readdata[7:0];
        read <= 1'h0;
        write <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        bus(1'h1, idx, d, r);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [7:0] r);
        bus(1'h0, idx, 8'h00, r);
    endtask

    // waits for the answer request and checks its delay window
    task automatic wait_act(input int lo, input int hi);
        int n;
        n = 0;
        c0 = n_act;
        while (n_act == c0 && n < hi) begin
            @(posedge clk);
            n++;
        end
        chk_bit(n >= lo && n < hi, 1'h1);
    endtask

    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        rst = 1'h1;
        read = 1'h0;
        write = 1'h0;
        address = 10'h0;
        writedata = 32'h0;
        byteenable = 4'hf;
        hook_off = 1'h0;
        ringing = 1'h0;
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        chk_feed(feed, {3'h0, 1'h0, 6'h20, 6'h02, 1'h0});
        for (int i = 0; i < 9; i++) begin
            rd(idx_tab[i], q);
            chk_byte(q, rst_tab[i]);
        end
        for (int i = 0; i < 9; i++) begin
            wr(idx_tab[i], 8'hff);
            rd(idx_tab[i], q);
            chk_byte(q, msk_tab[i]);
        end
        rd(8'h60, q);
        chk_byte(q, 8'h00);
        chk_feed(feed, {3'h7, 1'h1, 6'h3f, 6'h3f, 1'h1});
        // a write with the low byte lane disabled must leave the register alone
        byteenable <= 4'he;
        wr(8'h47, 8'h02);
        byteenable <= 4'hf;
        rd(8'h47, q);
        chk_byte(q, 8'h07);
        wr(8'h43, 8'h06);
        wr(8'h45, 8'h02);
        wr(8'h46, 8'h03);
        wr(8'h51, 8'h00);
        // one-cycle glitch must not reach the filtered flag
        hook_off <= 1'h1;
        @(posedge clk);
        hook_off <= 1'h0;
        repeat (30) @(posedge clk);
        rd(8'h44, q);
        chk_byte(q, 8'h04);
        chk_byte(n_act, 8'h00);
        hook_off <= 1'h1;
        wait_act(2 * TICK, 3 * TICK + 8);
        rd(8'h44, q);
        chk_byte(q, 8'h01);
        chk_bit(irq, 1'h0);
        rd(8'h50, q);
        chk_byte(q, 8'h01);
        wr(8'h51, 8'h01);
        @(posedge clk);
        chk_bit(irq, 1'h1);
        wr(8'h50, 8'h01);
        @(posedge clk);
        chk_bit(irq, 1'h0);
        hook_off <= 1'h0;
        repeat (40) @(posedge clk);
        rd(8'h44, q);
        chk_byte(q, 8'h04);
        ringing <= 1'h1;
        hook_off <= 1'h1;
        wait_act(3 * TICK, 4 * TICK + 8);
        rd(8'h44, q);
        chk_byte(q, 8'h02);
        hook_off <= 1'h0;
        ringing <= 1'h0;
        repeat (40) @(posedge clk);
        wr(8'h43, 8'h00);
        c0 = n_act;
        hook_off <= 1'h1;
        repeat (40) @(posedge clk);
        rd(8'h44, q);
        chk_byte(q, 8'h01);
        chk_byte(n_act, c0);
        wrap_up();
    end
endmodule // ldd_core_tb_top
